// *** rtl/fsc_fifo.sv ***
// Purpose: Upstream frame buffer with valid/ready on both sides
// Assumes: Single clock; flush empties it at once
// Notes:   Snapshot storage, so later writes never alter queued frames
`timescale 1ns/1ps
module fsc_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16,
   parameter int AW    = $clog2(DEPTH)
) (
   input  wire logic             clk_i,
   input  wire logic             rst_n_i,
   input  wire logic             flush_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic      [WIDTH-1:0] out_data_o
);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wp;
      logic [AW-1:0]               rp;
      logic [AW:0]                 cnt;
   } fsc_fifo_state_type;

   fsc_fifo_state_type q;
   fsc_fifo_state_type d;
   logic               push;
   logic               pop;

   // Honest full and empty flags
   assign in_ready_o  = (q.cnt != (AW+1)'(DEPTH));
   assign out_valid_o = (q.cnt != '0);
   assign out_data_o  = q.mem[q.rp];
   assign push        = in_valid_i && in_ready_o;
   assign pop         = out_valid_o && out_ready_i;

   // Pointer and count update
   always_comb begin
      d = q;
      if (push) begin
         d.mem[q.wp] = in_data_i;
         d.wp        = q.wp + AW'(1);
      end
      if (pop) begin
         d.rp = q.rp + AW'(1);
      end
      d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
      if (flush_i) begin
         d.wp  = '0;
         d.rp  = '0;
         d.cnt = '0;
      end
   end

   // State register
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

endmodule : fsc_fifo

// *** rtl/fsc_slave.sv ***
// Purpose: Fast serial channel slave, downstream receiver and upstream control
// Assumes: All pins synchronous to clk_i; downstream clock far slower than clk_i
// Notes:   Register file outside is read through reg_rd_addr_o/reg_rd_data_i
`timescale 1ns/1ps
`include "fsc_regs.svh"
module fsc_slave #(
   parameter int MON_CYCLES = `FSC_MON_CYCLES,
   parameter int FIFO_DEPTH = 16
) (
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   input  wire logic        clock_in_pos_i,
   input  wire logic        data_in_pos_i,
   input  wire logic        chip_select_n_i,
   input  wire logic [11:0] direct_drive_inputs_i,
   input  wire logic [11:0] direct_drive_select_i,
   input  wire logic [7:0]  reg_rd_data_i,
   output logic      [6:0]  reg_rd_addr_o,
   output logic             wr_valid_o,
   output logic      [6:0]  wr_addr_o,
   output logic      [7:0]  wr_data_o,
   output logic             upstream_out_o,
   output logic             upstream_out_oe_o,
   output logic      [27:0] output_control_regs_o,
   output logic      [23:0] output_enable_bits_o,
   output logic      [11:0] direct_drive_out_o,
   output logic             comm_timeout_o,
   output logic             upstream_busy_o
);
   localparam int MW = $clog2(MON_CYCLES + 1);
   localparam logic [MW-1:0] MON_LAST = MW'(MON_CYCLES - 1);
   localparam logic [MW-1:0] MON_END  = MW'(MON_CYCLES);

   typedef struct packed {
      fsc_pkg::fsc_main_state_type st;
      logic                        clk_prev;
      logic                        cs_prev;
      logic [4:0]                  cnt;
      logic [28:0]                 sh;
      logic [27:0]                 ctrl;
      logic [23:0]                 oe;
      logic [7:0]                  cfg_a;
      logic [7:0]                  cfg_b;
      logic                        timeout;
      logic [MW-1:0]               mon;
      logic [6:0]                  rd_addr;
      logic [1:0]                  k;
      logic                        multi;
      logic [3:0]                  fixed_a;
      logic                        ovf;
      logic                        wr_valid;
      logic [6:0]                  wr_addr;
      logic [7:0]                  wr_data;
   } fsc_main_reg_type;

   fsc_main_reg_type q;
   fsc_main_reg_type d;

   // ----------------------------------------------------------------------
   // Frame builder
   // ----------------------------------------------------------------------
   function automatic logic [15:0] fsc_frame(input logic       len16,
                                             input logic [3:0] addr,
                                             input logic [7:0] data);
      if (len16) begin
         fsc_frame = {2'b11, ^data, data, addr, 1'b0};
      end else begin
         fsc_frame = {4'h0, 2'b11, ^data, data, 1'b0};
      end
   endfunction : fsc_frame

   // ----------------------------------------------------------------------
   // Decode of the sampled pins and the received frame
   // ----------------------------------------------------------------------
   logic        fall;
   logic        cs_fall;
   logic        cs_rise;
   logic        cmd_ok;
   logic        data_ok;
   logic [7:0]  code;
   logic [7:0]  cdata;
   logic        rd_cmd;
   logic        wr_cmd;
   logic        up_busy;
   logic        len16;
   logic        mmode;
   logic        last_rd;
   logic [7:0]  rd_byte;
   logic        fifo_in_valid;
   logic        fifo_in_ready;
   logic [15:0] fifo_in_data;
   logic        fifo_out_valid;
   logic        fifo_out_ready;
   logic [15:0] fifo_out_data;
   logic        flush;
   logic        tx_busy;
   logic        tx_line;
   logic        tx_start;
   logic [15:0] tx_frame;

   assign fall    = q.clk_prev && !clock_in_pos_i;
   assign cs_fall = q.cs_prev && !chip_select_n_i;
   assign cs_rise = !q.cs_prev && chip_select_n_i;
   // Length and first (frame type) bit checked, no parity on downstream
   assign cmd_ok  = cs_rise && (q.cnt == `FSC_CMD_LEN) && q.sh[0];
   assign data_ok = cs_rise && (q.cnt == `FSC_DATA_LEN) && !q.sh[0];
   assign code    = q.sh[8:1];
   assign cdata   = q.sh[16:9];
   assign up_busy = (q.st == fsc_pkg::FSC_ST_PREP) || fifo_out_valid || tx_busy;
   assign rd_cmd  = cmd_ok && !code[`FSC_WR_FLAG];
   assign wr_cmd  = cmd_ok && code[`FSC_WR_FLAG] && (q.st != fsc_pkg::FSC_ST_PREP);
   assign len16   = q.cfg_a[`FSC_CFGA_LEN16];
   assign mmode   = q.cfg_b[`FSC_CFGB_MULTI];
   assign last_rd = !q.multi || (q.k == `FSC_MULTI_FRAMES);

   // Internal registers answer themselves, others come from outside
   always_comb begin
      case (q.rd_addr)
         `FSC_ADDR_OE0:   rd_byte = q.oe[7:0];
         `FSC_ADDR_OE1:   rd_byte = q.oe[15:8];
         `FSC_ADDR_OE2:   rd_byte = q.oe[23:16];
         `FSC_ADDR_CFG_A: rd_byte = q.cfg_a;
         `FSC_ADDR_CFG_B: rd_byte = q.cfg_b;
         `FSC_ADDR_DIAG:  rd_byte = {7'h00, q.timeout};
         default:         rd_byte = reg_rd_data_i;
      endcase
   end

   // Overflow flag rides in A0 of a 16-bit multi-read frame at the moment it leaves the queue
   assign tx_start       = fifo_out_valid && !tx_busy;
   assign fifo_out_ready = tx_start;
   assign tx_frame       = (len16 && mmode && q.ovf) ? (fifo_out_data | `FSC_A0_MASK)
                                                     : fifo_out_data;

   // ----------------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------------
   always_comb begin
      d             = q;
      d.wr_valid    = 1'b0;
      d.clk_prev    = clock_in_pos_i;
      d.cs_prev     = chip_select_n_i;
      fifo_in_valid = 1'b0;
      fifo_in_data  = 16'h0000;
      flush         = 1'b0;
      // Bit capture, LSB first, ignored while select is high
      if (cs_fall) begin
         d.cnt = 5'h00;
      end else if (fall && !chip_select_n_i) begin
         if (q.cnt < `FSC_DATA_LEN) begin
            d.sh[q.cnt] = data_in_pos_i;
         end
         if (q.cnt != `FSC_CNT_MAX) begin
            d.cnt = q.cnt + 5'h01;
         end
      end
      // Monitor: only a good data frame restarts it
      if (data_ok) begin
         d.mon = '0;
      end else if (q.mon != MON_END) begin // Parks one past the limit
         d.mon = q.mon + MW'(1);
      end
      // Preparation: snapshot each register into the queue
      if (q.st == fsc_pkg::FSC_ST_PREP) begin
         if (fifo_in_ready) begin
            fifo_in_valid = 1'b1;
            fifo_in_data  = fsc_frame(len16, mmode ? {q.k, !last_rd, 1'b0} : q.fixed_a,
                                      rd_byte);
            if (q.rd_addr == `FSC_ADDR_DIAG) begin
               d.timeout = 1'b0;
            end
            d.k       = q.k + 2'h1;
            d.rd_addr = q.rd_addr + 7'h01;
            if (last_rd) begin
               d.st = fsc_pkg::FSC_ST_IDLE;
            end
         end
      end
      if (tx_start && len16 && mmode) begin
         d.ovf = 1'b0;
      end
      // Write command, also while upstream sends, but not during preparation
      if (wr_cmd) begin
         d.wr_valid = 1'b1;
         d.wr_addr  = code[6:0];
         d.wr_data  = cdata;
         case (code[6:0])
            `FSC_ADDR_OE0:   d.oe[7:0]   = cdata;
            `FSC_ADDR_OE1:   d.oe[15:8]  = cdata;
            `FSC_ADDR_OE2:   d.oe[23:16] = cdata;
            `FSC_ADDR_CFG_A: d.cfg_a     = cdata;
            `FSC_ADDR_CFG_B: d.cfg_b     = cdata;
            `FSC_ADDR_CMD_A: begin
               if (cdata[`FSC_STOP_FLAG]) begin
                  flush = 1'b1;
                  d.st  = fsc_pkg::FSC_ST_IDLE;
               end
            end
            default: begin
            end
         endcase
      end
      if (data_ok) begin
         d.ctrl = q.sh[28:1];
      end
      // Read command: accepted only when all upstream is over
      if (rd_cmd) begin
         if (up_busy) begin
            d.ovf = 1'b1;
         end else begin
            d.st      = fsc_pkg::FSC_ST_PREP;
            d.rd_addr = code[6:0];
            d.k       = 2'h0;
            d.multi   = cdata[`FSC_MULTI_FLAG];
            d.fixed_a = q.cfg_b[3:0];
         end
      end
      // Timeout wins over register writes, not over a good data frame; fires once, so a cleared flag stays cleared
      if ((q.mon == MON_LAST) && !data_ok) begin
         d.timeout = 1'b1;
         d.ctrl    = '0;
         d.oe      = '0;
      end
   end

   // State register
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         q          <= '0;
         q.st       <= fsc_pkg::FSC_ST_IDLE;
         q.clk_prev <= 1'b0;
         q.cs_prev  <= 1'b1;
         q.cfg_a    <= `FSC_CFGA_RESET;
         q.cfg_b    <= `FSC_CFGB_RESET;
      end else begin
         q <= d;
      end
   end

   // ----------------------------------------------------------------------
   // Buffer and serialiser
   // ----------------------------------------------------------------------
   fsc_fifo #(
      .WIDTH (16),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk_i       (clk_i),
      .rst_n_i     (rst_n_i),
      .flush_i     (flush),
      .in_valid_i  (fifo_in_valid),
      .in_ready_o  (fifo_in_ready),
      .in_data_i   (fifo_in_data),
      .out_valid_o (fifo_out_valid),
      .out_ready_i (fifo_out_ready),
      .out_data_o  (fifo_out_data)
   );

   fsc_up_tx u_tx (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .tick_i  (fall),
      .div_i   (q.cfg_a[`FSC_CFGA_DIV_HI:0]),
      .len16_i (len16),
      .start_i (tx_start),
      .frame_i (tx_frame),
      .abort_i (flush),
      .line_o  (tx_line),
      .busy_o  (tx_busy)
   );

   // ----------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------
   assign upstream_out_o        = tx_line;
   assign upstream_out_oe_o     = q.cfg_a[`FSC_CFGA_PUSHPULL] || !tx_line;
   assign reg_rd_addr_o         = q.rd_addr;
   assign wr_valid_o            = q.wr_valid;
   assign wr_addr_o             = q.wr_addr;
   assign wr_data_o             = q.wr_data;
   assign output_control_regs_o = q.ctrl;
   assign output_enable_bits_o  = q.oe;
   assign comm_timeout_o        = q.timeout;
   assign upstream_busy_o       = up_busy;
   // Direct drive follows pins only once re-enabled
   assign direct_drive_out_o    = q.oe[11:0] & direct_drive_select_i
                                  & direct_drive_inputs_i;

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   property p_cmd_len;
      @(posedge clk_i) disable iff (!rst_n_i)
         q.wr_valid |-> $past(q.cnt) == `FSC_CMD_LEN;
   endproperty
   a_cmd_len: assert property (p_cmd_len) else $error("write without 17 bits");

   property p_timeout_off;
      @(posedge clk_i) disable iff (!rst_n_i)
         $rose(q.timeout) |-> (q.ctrl == '0) && (q.oe == '0);
   endproperty
   a_timeout_off: assert property (p_timeout_off) else $error("outputs on at timeout");

   property p_data_store;
      @(posedge clk_i) disable iff (!rst_n_i)
         data_ok |=> q.ctrl == $past(q.sh[28:1]);
   endproperty
   a_data_store: assert property (p_data_store) else $error("data frame not stored");

   property p_mon_restart;
      @(posedge clk_i) disable iff (!rst_n_i)
         data_ok |=> (q.mon == '0) && !$rose(q.timeout);
   endproperty
   a_mon_restart: assert property (p_mon_restart) else $error("monitor not restarted");

   property p_prep_nowrite;
      @(posedge clk_i) disable iff (!rst_n_i)
         (q.st == fsc_pkg::FSC_ST_PREP) |=> !q.wr_valid;
   endproperty
   a_prep_nowrite: assert property (p_prep_nowrite) else $error("write in preparation");

   property p_read_ignored;
      @(posedge clk_i) disable iff (!rst_n_i)
         (rd_cmd && up_busy) |=> q.ovf && $stable(q.rd_addr);
   endproperty
   a_read_ignored: assert property (p_read_ignored) else $error("busy read not ignored");

   property p_stop;
      @(posedge clk_i) disable iff (!rst_n_i)
         flush |=> !tx_busy && !fifo_out_valid && tx_line;
   endproperty
   a_stop: assert property (p_stop) else $error("upstream not stopped");

   property p_start_bit;
      @(posedge clk_i) disable iff (!rst_n_i)
         (tx_start && !flush) |=> !tx_line && tx_busy;
   endproperty
   a_start_bit: assert property (p_start_bit) else $error("no start bit");

   property p_open_drain;
      @(posedge clk_i) disable iff (!rst_n_i)
         !q.cfg_a[`FSC_CFGA_PUSHPULL] |-> (upstream_out_oe_o == !upstream_out_o);
   endproperty
   a_open_drain: assert property (p_open_drain) else $error("open drain drives high");

   c_data:    cover property (@(posedge clk_i) disable iff (!rst_n_i) data_ok);
   c_read:    cover property (@(posedge clk_i) disable iff (!rst_n_i) $rose(tx_busy));
   c_timeout: cover property (@(posedge clk_i) disable iff (!rst_n_i) $rose(q.timeout));
   c_stop:    cover property (@(posedge clk_i) disable iff (!rst_n_i) flush && tx_busy);

endmodule : fsc_slave

// *** rtl/fsc_up_tx.sv ***
// Purpose: Upstream frame serialiser, LSB first
// Assumes: tick_i marks each falling edge of the downstream clock
// Notes:   Bit time is (div_i + 1) downstream clock periods
`timescale 1ns/1ps
`include "fsc_regs.svh"
module fsc_up_tx (
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   input  wire logic        tick_i,
   input  wire logic [2:0]  div_i,
   input  wire logic        len16_i,
   input  wire logic        start_i,
   input  wire logic [15:0] frame_i,
   input  wire logic        abort_i,
   output logic             line_o,
   output logic             busy_o
);
   typedef struct packed {
      fsc_pkg::fsc_tx_state_type st;
      logic [15:0]               sh;
      logic [3:0]                bitn;
      logic [3:0]                last;
      logic [2:0]                divc;
      logic                      line;
   } fsc_tx_state_type;

   fsc_tx_state_type q;
   fsc_tx_state_type d;

   assign line_o = q.line;
   assign busy_o = (q.st == fsc_pkg::FSC_TX_SHIFT);

   // Bit timing derived from the downstream clock only, hence it must keep running
   always_comb begin
      d = q;
      case (q.st)
         fsc_pkg::FSC_TX_IDLE: begin
            d.line = 1'b1;
            if (start_i) begin
               d.st   = fsc_pkg::FSC_TX_SHIFT;
               d.sh   = frame_i;
               d.line = frame_i[0];
               d.bitn = 4'h0;
               d.divc = 3'h0;
               d.last = len16_i ? `FSC_LAST16 : `FSC_LAST12;
            end
         end
         fsc_pkg::FSC_TX_SHIFT: begin
            if (tick_i) begin
               if (q.divc == div_i) begin
                  d.divc = 3'h0;
                  if (q.bitn == q.last) begin
                     d.st   = fsc_pkg::FSC_TX_IDLE;
                     d.line = 1'b1;
                  end else begin
                     d.bitn = q.bitn + 4'h1;
                     d.sh   = {1'b1, q.sh[15:1]};
                     d.line = q.sh[1];
                  end
               end else begin
                  d.divc = q.divc + 3'h1;
               end
            end
         end
         default: begin
            d.st   = fsc_pkg::FSC_TX_IDLE;
            d.line = 1'b1;
         end
      endcase
      if (abort_i) begin
         d.st   = fsc_pkg::FSC_TX_IDLE;
         d.line = 1'b1;
      end
   end

   // State register
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         q      <= '0;
         q.st   <= fsc_pkg::FSC_TX_IDLE;
         q.line <= 1'b1;
      end else begin
         q <= d;
      end
   end

endmodule : fsc_up_tx

// *** shared/fsc_pkg.sv ***
// Purpose: Types shared by the fast serial channel slave
// Assumes: Used with explicit package scope only
// Notes:   State codes are one-hot
package fsc_pkg;

   // ----------------------------------------------------------------------
   // State enumerations
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {
      FSC_ST_IDLE = 2'b01,
      FSC_ST_PREP = 2'b10
   } fsc_main_state_type;

   typedef enum logic [1:0] {
      FSC_TX_IDLE  = 2'b01,
      FSC_TX_SHIFT = 2'b10
   } fsc_tx_state_type;

endpackage : fsc_pkg

// *** shared/fsc_regs.svh ***
// Purpose: Named constants of the fast serial channel slave
// Assumes: Included by its bare name from the slave, the serialiser and the bench top
// Notes:   Addresses are 7-bit register addresses carried in the command code
`ifndef FSC_REGS_SVH
`define FSC_REGS_SVH

// ----------------------------------------------------------------------
// Frame lengths and field positions
// ----------------------------------------------------------------------
`define FSC_CMD_LEN        5'h11
`define FSC_DATA_LEN       5'h1D
`define FSC_CNT_MAX        5'h1F
`define FSC_WR_FLAG        7
`define FSC_MULTI_FLAG     0
`define FSC_STOP_FLAG      0
`define FSC_A0_MASK        16'h0002
`define FSC_LAST12         4'hB
`define FSC_LAST16         4'hF

// ----------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------
`define FSC_ADDR_OE0       7'h10
`define FSC_ADDR_OE1       7'h11
`define FSC_ADDR_OE2       7'h12
`define FSC_ADDR_CFG_A     7'h20
`define FSC_ADDR_CFG_B     7'h21
`define FSC_ADDR_CMD_A     7'h22
`define FSC_ADDR_DIAG      7'h23

// ----------------------------------------------------------------------
// Configuration fields and reset values
// ----------------------------------------------------------------------
`define FSC_CFGA_DIV_HI    2
`define FSC_CFGA_PUSHPULL  3
`define FSC_CFGA_LEN16     4
`define FSC_CFGB_MULTI     4
`define FSC_CFGA_RESET     8'h08
`define FSC_CFGB_RESET     8'h00
`define FSC_MULTI_FRAMES   2'h3

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define FSC_CLK_MHZ        100
`define FSC_MON_TIME_US    500
`define FSC_MON_CYCLES     (`FSC_MON_TIME_US * `FSC_CLK_MHZ)

`endif

// *** tb/fsc_host_model.sv ***
// Purpose: Host model driving the downstream link
// Assumes: Link clock runs free
// Notes:   Data moves on rising link clock edge
`timescale 1ns/1ps
module fsc_host_model (
   output logic sclk_o,
   output logic sdat_o,
   output logic sel_n_o
);
   // ------------------------------
   // Link clock and frame sender
   // ------------------------------
   initial begin
      sclk_o = 1'b0;
      sdat_o = 1'b0;
      sel_n_o = 1'b1;
   end
   // Never stops, upstream timing needs it
   always #40 sclk_o = ~sclk_o;
   // Idle data inverted so stale bits never look valid
   task automatic send(input logic [31:0] bits, input int n);
      @(posedge sclk_o);
      sel_n_o = 1'b0;
      for (int i = 0; i < n; i++) begin
         sdat_o = bits[i];
         @(posedge sclk_o);
      end
      sel_n_o = 1'b1;
      sdat_o = ~sdat_o;
      repeat (3) @(posedge sclk_o);
   endtask : send
endmodule : fsc_host_model

// *** tb/fsc_slave_tb_top.sv ***
// Purpose: Self-checking bench for the channel slave
// Assumes: Short monitor interval
// Notes:   Write pulses matched against a queue
`timescale 1ns/1ps
`include "fsc_regs.svh"
module fsc_slave_tb_top;
   // ------------------------------
   // Signals and instances
   // ------------------------------
   localparam int MON = 2000;
   logic        clk_i = 1'b0;
   logic        rst_n_i = 1'b0;
   logic        sclk, sdat, sel_n, wr_valid, line, tmo, busy, up_oe;
   // Released open-drain line reads as its pull-up
   wire         pin = up_oe ? line : 1'b1;
   logic [11:0] dd_in = '0, dd_sel = '0, dd_out;
   logic [15:0] got;
   logic [7:0]  rd_data = '0, wr_data;
   logic [6:0]  wr_addr, rd_addr;
   logic [27:0] ctrl, d;
   logic [23:0] oe;
   logic [14:0] exp_q[$];
   int          n_mismatch = 0, checked = 0, seed = 95;
   always #5 clk_i = ~clk_i;
   fsc_host_model fsc_host_model_i (.sclk_o(sclk), .sdat_o(sdat), .sel_n_o(sel_n));
   fsc_slave #(.MON_CYCLES(MON)) fsc_slave_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
      .clock_in_pos_i(sclk), .data_in_pos_i(sdat), .chip_select_n_i(sel_n),
      .direct_drive_inputs_i(dd_in), .direct_drive_select_i(dd_sel),
      .reg_rd_data_i(rd_data), .reg_rd_addr_o(rd_addr), .wr_valid_o(wr_valid),
      .wr_addr_o(wr_addr), .wr_data_o(wr_data), .upstream_out_o(line),
      .upstream_out_oe_o(up_oe), .output_control_regs_o(ctrl), .output_enable_bits_o(oe),
      .direct_drive_out_o(dd_out), .comm_timeout_o(tmo), .upstream_busy_o(busy));
   task automatic check(input logic [63:0] g, input logic [63:0] e);
      checked++;
      if (g !== e) begin
         n_mismatch++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : check
   task automatic wrap_up();
      if (n_mismatch == 0 && checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : wrap_up
   // Expectation noted before the frame leaves
   task automatic wr(input logic [6:0] a, input logic [7:0] b);
      exp_q.push_back({a, b});
      fsc_host_model_i.send({b, 1'b1, a, 1'b1}, 17);
   endtask : wr
   // Capture runs beside the read, one sample per upstream bit time
   task automatic rd(input logic [6:0] a, input logic [7:0] c, input int n, input int dv);
      got = '0;
      fork
         fsc_host_model_i.send({c, 1'b0, a, 1'b1}, 17);
         begin
            wait (pin === 1'b0);
            for (int i = 0; i < n; i++) begin
               @(negedge sclk) got[i] = pin;
               repeat (dv) @(negedge sclk);
            end
         end
      join
      wait (busy === 1'b0);
   endtask : rd
   // Each write pulse takes the oldest note
   // Sampled off the launch edge, so the pulse has settled
   always @(negedge clk_i)
      if (wr_valid === 1'b1) check({wr_addr, wr_data}, exp_q.size() ? exp_q.pop_front() : 'x);
   // ------------------------------
   // Main sequence and watchdog
   // ------------------------------
   initial begin
      repeat (20) @(posedge clk_i);
      @(negedge clk_i) rst_n_i = 1'b1;
      rd_data = 8'($random(seed));
      rd(7'h05, 8'h00, 12, 0);
      check(got, {2'b11, ^rd_data, rd_data, 1'b0});
      for (int k = 0; k < 3; k++) wr(7'h01 + 7'(k), 8'($random(seed)));
      wr(`FSC_ADDR_OE0, 8'hFF);
      check(oe[7:0], 8'hFF);
      fsc_host_model_i.send({8'h5A, 1'b1, 7'h01, 1'b1}, 16);
      fsc_host_model_i.send({1'b0, 8'h5A, 1'b1, 7'h01, 1'b1}, 18);
      fsc_host_model_i.send({8'h5A, 1'b1, 7'h01, 1'b1}, 6);
      repeat (8) begin
         d = 28'($random(seed));
         fsc_host_model_i.send({d, 1'b0}, 29);
         check({tmo, ctrl}, {1'b0, d});
      end
      fsc_host_model_i.send({~d, 1'b0}, 28);
      check(ctrl, d);
      repeat (MON + 10) @(posedge clk_i);
      check({tmo, ctrl, oe}, {1'b1, 52'h0});
      rd(`FSC_ADDR_DIAG, 8'h00, 12, 0);
      check({tmo, ctrl, oe}, 64'h0);
      @(negedge clk_i) begin
         dd_in = 12'($random(seed));
         dd_sel = 12'($random(seed));
      end
      wr(`FSC_ADDR_OE0, 8'hFF);
      wr(`FSC_ADDR_OE1, 8'h0F);
      check({ctrl, dd_out}, {28'h0, dd_in & dd_sel});
      // Fixed address 5, open drain, sixteen bits, two link clocks per bit
      wr(`FSC_ADDR_CFG_B, 8'h05);
      wr(`FSC_ADDR_CFG_A, 8'h11);
      rd(`FSC_ADDR_CFG_B, 8'h00, 16, 1);
      check(got, {2'b11, ^8'h05, 8'h05, 4'h5, 1'b0});
      // Multi read; an ignored read and a stop land while frames are queued
      wr(`FSC_ADDR_CFG_B, 8'h10);
      fork
         rd(`FSC_ADDR_CFG_A, 8'h01, 16, 1);
         begin
            wait (pin === 1'b0);
            repeat (4) @(posedge sclk);
            fsc_host_model_i.send({8'h00, 1'b0, 7'h05, 1'b1}, 17);
            wr(`FSC_ADDR_CMD_A, 8'h01);
            check({busy, pin, rd_addr}, {2'b01, 7'h24});
         end
      join
      check(got, {2'b11, ^8'h11, 8'h11, 4'h2, 1'b0});
      wrap_up();
   end
   // Run needs about 80 us
   initial begin
      #300us;
      n_mismatch++;
      wrap_up();
   end
endmodule : fsc_slave_tb_top
